// ---- rtl/psc_status_sender.sv ----
/*
 * Pool status sender: builds status frames and serialises them on one
 * status line, one bit per clock.
 * Assumes the far end frames the stream, keeps the credit counters and
 * holds a calendar identical to the one written here.
 */
`timescale 1ns/1ps
`default_nettype none

module psc_status_sender (
    // Clock and reset
    input  wire logic                                i_clk,
    input  wire logic                                i_rst_n,
    // Calendar configuration, one entry per parameter set
    input  wire psc_pkg::psc_cfg_s [1:0]             i_cfg,
    input  wire psc_pkg::psc_cal_wr_s                i_cal_wr,
    // Pool fill levels from the receive buffers
    input  wire logic [psc_pkg::PSC_POOLS-1:0][1:0]  i_pool_status,
    // Parameter set switch request, one-cycle pulse
    input  wire logic                                i_switch_req,
    // Status line and indications
    output logic                                     o_status_line,
    output logic                                     o_frame_start,
    output logic                                     o_active_set,
    output logic                                     o_switch_busy,
    output logic                                     o_cfg_error
);

    import psc_pkg::*;

    ////////////////////////////////////////////////////////////////////////

    psc_state_e                state_reg;
    psc_state_e                state_next;
    logic                      phase_reg;
    psc_word_t                 word_reg;
    psc_word_t                 word_next;
    logic [PSC_CAL_AW-1:0]     entry_reg;
    logic [PSC_REP_W-1:0]      rep_reg;
    logic [PSC_CAL_AW:0]       len_reg;
    logic [PSC_REP_W-1:0]      reps_reg;
    psc_word_t                 par_reg;
    logic                      active_reg;
    logic                      pend_reg;
    logic                      seq_active_reg;
    logic [2:0]                seq_idx_reg;
    logic [PSC_CNT_W-1:0]      word_cnt_reg;
    logic                      last_entry;
    logic                      last_rep;
    logic                      seq_start;
    logic [PSC_CAL_AW-1:0]     rd_idx;
    psc_entry_s                cal_rd;
    logic [PSC_POOL_W-1:0]     rd_pool;
    psc_word_t                 rd_status;
    psc_word_t                 report_word;
    psc_word_t                 switch_word;
    psc_word_t                 dip_word;
    psc_word_t                 new_code;
    psc_word_t                 old_code;
    psc_cfg_s                  cfg_sel;

    generate
        if (PSC_POOLS != (1 << PSC_POOL_W)) begin : g_bad_pools
            $error("psc_status_sender: pool count must be 2**select width");
        end
        if (PSC_POOL_W > PSC_PA_W) begin : g_bad_pool_w
            $error("psc_status_sender: pool select wider than address");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Calendar lookup. The read is issued in the first bit of a word so
    // that the entry is ready when the next word is chosen.

    assign last_entry = (entry_reg == len_reg[PSC_CAL_AW-1:0] -
                         PSC_LEN_ONE[PSC_CAL_AW-1:0]) ||
                        (len_reg == PSC_LEN_MAX &&
                         entry_reg == '1);
    assign last_rep   = (rep_reg == reps_reg - PSC_REP_ONE);

    always_comb begin
        if (state_reg == PSC_ST_FRAME || last_entry) begin
            rd_idx = '0;
        end else begin
            rd_idx = entry_reg + PSC_LEN_ONE[PSC_CAL_AW-1:0];
        end
    end

    psc_cal_mem #(
        .WIDTH ($bits(psc_entry_s)),
        .AW    (PSC_CAL_AW + 1),
        .DEPTH (2 * PSC_CAL_MAX)
    ) u_cal_mem (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_we    (i_cal_wr.we),
        .i_waddr ({i_cal_wr.set, i_cal_wr.idx}),
        .i_wdata (i_cal_wr.entry),
        .i_raddr ({active_reg, rd_idx}),
        .o_rdata (cal_rd)
    );

    assign rd_pool   = cal_rd.port[PSC_POOL_W-1:0];
    assign rd_status = i_pool_status[rd_pool];

    // A stray 11 from the buffer logic would look like a frame boundary,
    // so it is sent as satisfied, which grants nothing.
    always_comb begin
        if (!cal_rd.valid || rd_status == PSC_W_FRAME) begin
            report_word = PSC_W_SAT;
        end else begin
            report_word = rd_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Switch word and parity.

    assign new_code  = active_reg ? PSC_W_SET1 : PSC_W_SET2;
    assign old_code  = active_reg ? PSC_W_SET2 : PSC_W_SET1;
    assign seq_start = pend_reg && !seq_active_reg;

    always_comb begin
        if (seq_active_reg && seq_idx_reg == PSC_SEQ_NEW) begin
            switch_word = new_code;
        end else if (seq_active_reg && seq_idx_reg == PSC_SEQ_OLD) begin
            switch_word = old_code;
        end else if (seq_active_reg || seq_start) begin
            switch_word = PSC_W_SWNULL;
        end else begin
            switch_word = old_code;
        end
    end

    assign dip_word = ~({par_reg[0], par_reg[1]} ^ PSC_PAR_SLOT);

    ////////////////////////////////////////////////////////////////////////
    // Word sequencing; a new word is chosen at the end of its second bit.

    always_comb begin
        state_next = state_reg;
        word_next  = word_reg;
        case (state_reg)
            PSC_ST_FRAME: begin
                state_next = PSC_ST_REPORT;
                word_next  = report_word;
            end
            PSC_ST_REPORT: begin
                if (last_entry && last_rep) begin
                    state_next = PSC_ST_SWITCH;
                    word_next  = switch_word;
                end else begin
                    word_next  = report_word;
                end
            end
            PSC_ST_SWITCH: begin
                state_next = PSC_ST_PARITY;
                word_next  = dip_word;
            end
            PSC_ST_PARITY: begin
                state_next = PSC_ST_FRAME;
                word_next  = PSC_W_FRAME;
            end
            default: begin
                state_next = PSC_ST_FRAME;
                word_next  = PSC_W_FRAME;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= PSC_ST_FRAME;
            word_reg  <= PSC_W_FRAME;
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= ~phase_reg;
            if (phase_reg) begin
                state_reg <= state_next;
                word_reg  <= word_next;
            end
        end
    end

    // Calendar position; lengths are latched once per frame so a change
    // on the configuration ports never tears a frame apart.
    assign cfg_sel = i_cfg[active_reg];

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            entry_reg   <= '0;
            rep_reg     <= '0;
            len_reg     <= PSC_LEN_ONE;
            reps_reg    <= PSC_REP_ONE;
            o_cfg_error <= 1'b0;
        end else if (phase_reg && state_reg == PSC_ST_FRAME) begin
            entry_reg   <= '0;
            rep_reg     <= '0;
            o_cfg_error <= !psc_len_ok(cfg_sel.len) || cfg_sel.reps == '0;
            // An illegal length falls back to a single entry.
            len_reg     <= psc_len_ok(cfg_sel.len) ? cfg_sel.len
                                                   : PSC_LEN_ONE;
            reps_reg    <= (cfg_sel.reps == '0) ? PSC_REP_ONE
                                                : cfg_sel.reps;
        end else if (phase_reg && state_reg == PSC_ST_REPORT) begin
            entry_reg <= rd_idx;
            if (last_entry) begin
                rep_reg <= rep_reg + PSC_REP_ONE;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            par_reg <= PSC_PAR_ZERO;
        end else if (phase_reg && state_reg == PSC_ST_FRAME) begin
            par_reg <= word_next;
        end else if (phase_reg && state_reg == PSC_ST_REPORT) begin
            par_reg <= {par_reg[0], par_reg[1]} ^ word_next;
        end
    end

    // Parameter set switching. A request during a running sequence waits
    // for the next one; the set bit wins over its own clear.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_reg       <= 1'b0;
            seq_active_reg <= 1'b0;
            seq_idx_reg    <= PSC_SEQ_FIRST;
            active_reg     <= 1'b0;
        end else begin
            if (phase_reg && state_reg == PSC_ST_REPORT &&
                state_next == PSC_ST_SWITCH && seq_start) begin
                seq_active_reg <= 1'b1;
                seq_idx_reg    <= PSC_SEQ_FIRST;
                pend_reg       <= i_switch_req;
            end else begin
                if (i_switch_req) begin
                    pend_reg <= 1'b1;
                end
                if (phase_reg && state_reg == PSC_ST_SWITCH &&
                    seq_active_reg) begin
                    if (seq_idx_reg == PSC_SEQ_LAST) begin
                        seq_active_reg <= 1'b0;
                        active_reg     <= ~active_reg;
                    end else begin
                        seq_idx_reg <= seq_idx_reg + 3'h1;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_status_line <= 1'b1;
            o_frame_start <= 1'b0;
            o_active_set  <= 1'b0;
            o_switch_busy <= 1'b0;
        end else begin
            // One status line per direction of transfer.
            o_status_line <= phase_reg ? word_reg[0] : word_reg[1];
            o_frame_start <= !phase_reg && state_reg == PSC_ST_FRAME;
            o_active_set  <= active_reg;
            o_switch_busy <= pend_reg || seq_active_reg;
        end
    end

    // Word index within the frame, read only by the checks below.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            word_cnt_reg <= '0;
        end else if (phase_reg && state_reg == PSC_ST_FRAME) begin
            word_cnt_reg <= PSC_CNT_W'(1);
        end else if (phase_reg) begin
            word_cnt_reg <= word_cnt_reg + PSC_CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    a_msb_first: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !phase_reg |=> o_status_line == $past(word_reg[1]))
        else $error("upper bit not sent first");

    a_lsb_second: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        phase_reg |=> o_status_line == $past(word_reg[0]))
        else $error("lower bit not sent second");

    a_frame_order: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        phase_reg && state_reg == PSC_ST_PARITY |=>
        state_reg == PSC_ST_FRAME && word_reg == PSC_W_FRAME ##1
        state_reg == PSC_ST_FRAME ##1 state_reg == PSC_ST_REPORT)
        else $error("framing word does not follow parity");

    a_body_no_frame: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_reg == PSC_ST_REPORT || state_reg == PSC_ST_SWITCH |->
        word_reg != PSC_W_FRAME)
        else $error("delimiter inside frame body");

    a_frame_length: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_reg == PSC_ST_PARITY |->
        word_cnt_reg == PSC_CNT_W'(len_reg) * PSC_CNT_W'(reps_reg) +
        PSC_CNT_OVH)
        else $error("report count differs from length times reps");

    a_unprov_sat: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        phase_reg && state_next == PSC_ST_REPORT && !cal_rd.valid |=>
        word_reg == PSC_W_SAT)
        else $error("unprovisioned slot not satisfied");

    a_steady_set: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_reg == PSC_ST_SWITCH && !seq_active_reg |->
        word_reg == (active_reg ? PSC_W_SET2 : PSC_W_SET1))
        else $error("steady switch word wrong");

    a_seq_new_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_reg == PSC_ST_SWITCH && seq_active_reg &&
        seq_idx_reg == PSC_SEQ_NEW |->
        word_reg == (active_reg ? PSC_W_SET1 : PSC_W_SET2))
        else $error("second switch word is not the new set");

    a_seq_toggle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        phase_reg && state_reg == PSC_ST_SWITCH && seq_active_reg &&
        seq_idx_reg == PSC_SEQ_LAST |=>
        active_reg != $past(active_reg) ##2 o_active_set == active_reg)
        else $error("set not changed after fifth switch word");

    a_len_legal: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_reg == PSC_ST_REPORT |-> psc_len_ok(len_reg))
        else $error("illegal calendar length in use");

endmodule : psc_status_sender

`default_nettype wire

// ---- rtl/psc_pkg.sv ----
/*
 * Shared constants and types for the pool status sender.
 * Assumes one clock; the calendar, its lengths and the pool status
 * come from logic on that same clock.
 */
package psc_pkg;

    // Calendar and pool sizing.
    localparam int PSC_CAL_MAX = 64;
    localparam int PSC_CAL_AW  = 6;
    localparam int PSC_REP_W   = 8;
    localparam int PSC_PA_W    = 8;
    localparam int PSC_POOL_W  = 6;
    localparam int PSC_POOLS   = 64;
    localparam int PSC_CNT_W   = PSC_CAL_AW + PSC_REP_W + 2;

    // Two-bit words of the status frame.
    typedef logic [1:0] psc_word_t;
    localparam psc_word_t PSC_W_FRAME  = 2'h3;
    localparam psc_word_t PSC_W_SAT    = 2'h2;
    localparam psc_word_t PSC_W_HUNGRY = 2'h1;
    localparam psc_word_t PSC_W_STARVE = 2'h0;
    localparam psc_word_t PSC_W_SET1   = 2'h1;
    localparam psc_word_t PSC_W_SET2   = 2'h2;
    localparam psc_word_t PSC_W_SWNULL = 2'h0;
    localparam psc_word_t PSC_PAR_SLOT = 2'h3;
    localparam psc_word_t PSC_PAR_ZERO = 2'h0;

    // Switch sequence: five frames, code words at steps one and three.
    localparam logic [2:0] PSC_SEQ_FIRST = 3'h0;
    localparam logic [2:0] PSC_SEQ_NEW   = 3'h1;
    localparam logic [2:0] PSC_SEQ_OLD   = 3'h3;
    localparam logic [2:0] PSC_SEQ_LAST  = 3'h4;

    // Counter and length constants.
    localparam logic [PSC_CAL_AW:0]  PSC_LEN_ONE  = 7'h01;
    localparam logic [PSC_CAL_AW:0]  PSC_LEN_TWO  = 7'h02;
    localparam logic [PSC_CAL_AW:0]  PSC_LEN_FOUR = 7'h04;
    localparam logic [PSC_CAL_AW:0]  PSC_LEN_MAX  = 7'h40;
    localparam logic [PSC_REP_W-1:0] PSC_REP_ONE  = 8'h01;
    localparam logic [PSC_CNT_W-1:0] PSC_CNT_OVH  = 16'h0002;

    typedef struct packed {
        logic [PSC_CAL_AW:0]  len;
        logic [PSC_REP_W-1:0] reps;
    } psc_cfg_s;

    typedef struct packed {
        logic                valid;
        logic [PSC_PA_W-1:0] port;
    } psc_entry_s;

    typedef struct packed {
        logic                  we;
        logic                  set;
        logic [PSC_CAL_AW-1:0] idx;
        psc_entry_s            entry;
    } psc_cal_wr_s;

    typedef enum logic [1:0] {
        PSC_ST_FRAME,
        PSC_ST_REPORT,
        PSC_ST_SWITCH,
        PSC_ST_PARITY
    } psc_state_e;

    function automatic logic psc_len_ok(input logic [PSC_CAL_AW:0] len);
        psc_len_ok = (len == PSC_LEN_ONE) || (len == PSC_LEN_TWO) ||
                     (len == PSC_LEN_FOUR) ||
                     ((len != '0) && (len[2:0] == 3'h0) &&
                      (len <= PSC_LEN_MAX));
    endfunction : psc_len_ok

endpackage : psc_pkg

// ---- rtl/psc_cal_mem.sv ----
/*
 * Calendar store: one write port, one read port, registered read data.
 * Assumes the reader presents its address one cycle before it needs data.
 */
`timescale 1ns/1ps
`default_nettype none

module psc_cal_mem #(
    parameter int WIDTH = 9,
    parameter int AW    = 7,
    parameter int DEPTH = 128
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // Write side
    input  wire logic             i_we,
    input  wire logic [AW-1:0]    i_waddr,
    input  wire logic [WIDTH-1:0] i_wdata,
    // Read side
    input  wire logic [AW-1:0]    i_raddr,
    output logic      [WIDTH-1:0] o_rdata
);

    logic [WIDTH-1:0] mem_reg [DEPTH];

    generate
        if (DEPTH != (1 << AW)) begin : g_bad_depth
            $error("psc_cal_mem: DEPTH must equal 2**AW");
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_reg[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem_reg[i_raddr];
        end
    end

endmodule : psc_cal_mem

`default_nettype wire

// ---- sim/psc_frame_rx.sv ----
/* Receiver model of the status stream: frames it, checks parity and keeps
   per-slot credits. Assumes the sender's frame start marks word 11. */
`timescale 1ns/1ps
`default_nettype none

module psc_frame_rx #(
    parameter int GRANT1 = 8,
    parameter int FLOOR2 = 4
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // Status stream
    input  wire logic i_status_line,
    input  wire logic i_frame_start
);
    logic [1:0] cur[$];
    logic [1:0] last_words[$];
    logic [1:0] last_sw;
    logic [1:0] sw_prev;
    logic [9:0] sw_hist;
    logic       hi_bit;
    logic       last_ok;
    logic       in_frame;
    logic       active_set;
    int         nbits;
    int         last_bits;
    int         frames;
    int         good_run;
    int         bad_run;
    int         sw_run;
    int         credit[64];

    ////////////////////////////////////////////////////////////
    task automatic close_frame();
        logic [1:0] acc;
        int         n;
        int         sw_dist;
        n = cur.size();
        acc = cur[1];
        last_ok = (n > 3) && (cur[0] === 2'h3);
        for (int i = 2; i < n - 1; i++) begin
            acc = {acc[0], acc[1]} ^ cur[i];
        end
        for (int i = 1; i < n - 1; i++) begin
            if (cur[i] === 2'h3) last_ok = 1'b0;
        end
        if (cur[n-1] !== ~({acc[0], acc[1]} ^ 2'h3)) last_ok = 1'b0;
        // A single bad frame must never cost the credits.
        if (last_ok) begin
            good_run++;
            bad_run = 0;
            if (good_run >= 2) in_frame = 1'b1;
        end else begin
            bad_run++;
            good_run = 0;
            if (bad_run >= 2) begin
                in_frame = 1'b0;
                credit = '{default: 0};
            end
        end
        for (int i = 1; in_frame && i < n - 2; i++) begin
            if (cur[i] === 2'h0) credit[i-1] = GRANT1;
            else if (cur[i] === 2'h1 && credit[i-1] < FLOOR2)
                credit[i-1] = FLOOR2;
        end
        last_sw = cur[n-2];
        // Only the pattern that leaves the current set is decoded, and the
        // history restarts after a switch, so a shifted window of the same
        // sequence can never match a second time.
        sw_hist = {sw_hist[7:0], last_sw};
        sw_dist = $countones(sw_hist ^ (active_set ? 10'h048 : 10'h084));
        if (sw_dist <= 2) begin
            active_set = !active_set;
            sw_hist = active_set ? 10'h2AA : 10'h155;
        end
        if (last_sw === sw_prev && last_sw inside {2'h1, 2'h2}) sw_run++;
        else sw_run = 1;
        if (sw_run >= 5) active_set = (last_sw === 2'h2);
        sw_prev = last_sw;
        last_words = cur;
        last_bits = nbits;
        frames++;
    endtask : close_frame

    // Data source side: spends credit for a transfer of nbytes data bytes.
    // Control and training words are never counted, so they cost nothing.
    function automatic logic send_data(input int slot, input int nbytes);
        int blocks;
        blocks = (nbytes + 31) / 32;
        if (credit[slot] < blocks) return 1'b0;
        for (int b = 0; b < blocks; b++) begin
            if (credit[slot] > 0) credit[slot]--;
        end
        return 1'b1;
    endfunction : send_data

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur = {};
            nbits = 0;
            frames = 0;
            good_run = 0;
            bad_run = 0;
            sw_run = 0;
            credit = '{default: 0};
            in_frame = 1'b0;
            active_set = 1'b0;
            sw_prev = 2'h0;
            sw_hist = 10'h155;
        end else begin
            if (i_frame_start) begin
                if (nbits > 0) close_frame();
                cur = {};
                nbits = 0;
            end
            if (nbits[0] == 1'b0) hi_bit = i_status_line;
            else cur.push_back({hi_bit, i_status_line});
            nbits++;
        end
    end
endmodule : psc_frame_rx

`default_nettype wire

// ---- sim/psc_status_sender_tb_top.sv ----
/* Testbench of the pool status sender: drives calendar, pool status and
   switch requests; judges frames decoded by the receiver model. */
`timescale 1ns/1ps
`default_nettype none

module psc_status_sender_tb_top;
    import psc_pkg::*;
    logic                      i_clk = 1'b0;
    logic                      i_rst_n = 1'b0;
    logic                      i_switch_req = 1'b0;
    psc_cfg_s [1:0]            i_cfg;
    psc_cal_wr_s               i_cal_wr;
    logic [PSC_POOLS-1:0][1:0] i_pool_status;
    logic                      o_status_line;
    logic                      o_frame_start;
    logic                      o_active_set;
    logic                      o_switch_busy;
    logic                      o_cfg_error;
    int                        error_cnt = 0;
    int                        check_count = 0;

    always #20 i_clk = ~i_clk;

    psc_status_sender i_psc_status_sender (.i_clk, .i_rst_n, .i_cfg,
        .i_cal_wr, .i_pool_status, .i_switch_req, .o_status_line,
        .o_frame_start, .o_active_set, .o_switch_busy, .o_cfg_error);
    psc_frame_rx i_psc_frame_rx (.i_clk, .i_rst_n,
        .i_status_line(o_status_line), .i_frame_start(o_frame_start));

    ////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_body(input logic [1:0] exp[$]);
        for (int i = 0; i < exp.size(); i++) begin
            chk(i_psc_frame_rx.last_words[i], exp[i]);
        end
    endtask : chk_body

    // Frames are counted at the falling edge, after the model has run.
    task automatic wait_frames(input int n);
        int f0;
        repeat (n) begin
            f0 = i_psc_frame_rx.frames;
            for (int t = 0; t < 200 && i_psc_frame_rx.frames == f0; t++)
                @(negedge i_clk);
            if (i_psc_frame_rx.frames == f0) begin
                error_cnt++;
                stop_test();
            end
        end
    endtask : wait_frames

    task automatic cal_write(input logic s, input logic [5:0] idx,
                             input logic v, input logic [7:0] port);
        @(posedge i_clk);
        i_cal_wr <= '{we: 1'b1, set: s, idx: idx,
                      entry: '{valid: v, port: port}};
        @(posedge i_clk);
        i_cal_wr.we <= 1'b0;
    endtask : cal_write

    task automatic run_walk();
        @(posedge i_clk);
        @(negedge i_clk);
        chk({o_status_line, o_frame_start}, 2'h3);
        wait_frames(5);
        chk_body('{2'h3, 2'h0, 2'h1, 2'h2});
        chk(i_psc_frame_rx.last_bits, 8);
        chk(i_psc_frame_rx.credit[0], 8);
    endtask : run_walk

    task automatic run_calendar();
        cal_write(1'b0, 6'h01, 1'b0, 8'h00);
        cal_write(1'b0, 6'h02, 1'b1, 8'h05);
        cal_write(1'b0, 6'h03, 1'b1, 8'h3A);
        cal_write(1'b0, 6'h00, 1'b1, 8'hC5);
        @(posedge i_clk);
        i_cfg[0] <= '{len: 7'h04, reps: 8'h02};
        i_pool_status[5] <= 2'h1;
        i_pool_status[58] <= 2'h2;
        wait_frames(3);
        chk_body('{2'h3, 2'h1, 2'h2, 2'h1, 2'h2, 2'h1, 2'h2, 2'h1, 2'h2,
                   2'h1, 2'h2});
        chk(i_psc_frame_rx.last_bits, 22);
        chk(i_psc_frame_rx.credit[0], 8);
        chk(i_psc_frame_rx.credit[1], 0);
        chk(i_psc_frame_rx.credit[2], 4);
        chk(i_psc_frame_rx.send_data(2, 100), 1'b1);
        chk(i_psc_frame_rx.credit[2], 0);
        chk(i_psc_frame_rx.send_data(2, 1), 1'b0);
    endtask : run_calendar

    task automatic run_bad_cfg();
        @(posedge i_clk);
        i_cfg[0] <= '{len: 7'h03, reps: 8'h00};
        wait_frames(3);
        chk(o_cfg_error, 1'b1);
        chk_body('{2'h3, 2'h1, 2'h1, 2'h3});
        chk(i_psc_frame_rx.last_ok, 1'b1);
        for (int i = 4; i < 8; i++) cal_write(1'b0, 6'(i), 1'b0, 8'h00);
        @(posedge i_clk);
        i_cfg[0] <= '{len: 7'h08, reps: 8'h01};
        wait_frames(3);
        chk(o_cfg_error, 1'b0);
        chk(i_psc_frame_rx.last_bits, 22);
    endtask : run_bad_cfg

    task automatic run_switch(input logic to_set);
        logic [1:0] sw[$];
        logic [1:0] nw;
        int         j;
        nw = to_set ? 2'h2 : 2'h1;
        j = 0;
        @(posedge i_clk);
        i_switch_req <= 1'b1;
        @(posedge i_clk);
        i_switch_req <= 1'b0;
        @(posedge i_clk);
        @(negedge i_clk);
        chk(o_switch_busy, 1'b1);
        repeat (9) begin
            wait_frames(1);
            sw.push_back(i_psc_frame_rx.last_sw);
        end
        while (j < 3 && sw[j] !== 2'h0) j++;
        chk({sw[j], sw[j+1], sw[j+2], sw[j+3], sw[j+4], sw[j+5]},
            {2'h0, nw, 2'h0, ~nw, 2'h0, nw});
        chk({o_active_set, o_switch_busy}, {to_set, 1'b0});
        chk(i_psc_frame_rx.active_set, to_set);
        chk(i_psc_frame_rx.last_bits, to_set ? 8 : 22);
    endtask : run_switch

    initial begin
        i_cfg[0] = '{len: 7'h01, reps: 8'h01};
        i_cfg[1] = '{len: 7'h01, reps: 8'h01};
        i_cal_wr = '0;
        i_pool_status = '0;
        // The calendar is not reset, so its first entry is written while
        // reset holds; otherwise the first frame would carry unknowns.
        repeat (8) @(posedge i_clk);
        cal_write(1'b0, 6'h00, 1'b1, 8'h43);
        @(negedge i_clk);
        chk({o_status_line, o_frame_start, o_active_set, o_switch_busy,
             o_cfg_error}, 5'h10);
        @(posedge i_clk);
        i_rst_n <= 1'b1;
        run_walk();
        run_calendar();
        run_bad_cfg();
        cal_write(1'b1, 6'h00, 1'b1, 8'h03);
        run_switch(1'b1);
        run_switch(1'b0);
        stop_test();
    end
endmodule : psc_status_sender_tb_top

`default_nettype wire
